// ### svpwm_hall_model.sv
// svpwm_hall_model: hall speed sensor as seen through the capture unit
// assumes period_event is a one-cycle pulse from the sequencer
`timescale 1ns/1ps
module svpwm_hall_model #(
    parameter int EVERY = 3  // periods between rising hall edges
)
(
    // clock and pacing
    input  wire logic   clk_sys,
    input  wire logic   period_event,
    // capture unit
    output logic        capture_flag,
    output logic [15:0] capture_count
);
    int   n    = 0;     // periods since last edge
    logic pend = 1'b0;  // event seen, update due
    initial begin
        capture_flag  = 1'b0;
        capture_count = 16'h0000;
    end
    // update one cycle after the event so the sampling edge sees steady values
    always @(negedge clk_sys) begin
        if (period_event) begin
            pend <= 1'b1;
        end else if (pend) begin
            pend <= 1'b0;
            n = (n + 1) % EVERY;
            capture_flag <= (n == 0);
            // without an edge the count is stale, so it keeps changing
            capture_count <= (n == 0) ? 16'(100 + $urandom % 400) : ~capture_count;
        end
    end
endmodule

// ### svpwm_pi.sv
// svpwm_pi: proportional-integral speed regulator, one step per strobe
// assumes step strobe is a single-cycle pulse
`timescale 1ns/1ps
module svpwm_pi
    import svpwm_pkg::*;
(
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    input  wire logic                 clk_en,
    // operands
    input  wire logic                 step,
    input  wire logic signed [DW-1:0] setpoint,
    input  wire logic signed [DW-1:0] measured,
    // result
    output logic signed [DW-1:0]      out_r
);
    logic signed [DW-1:0] integ_r;   // integrator state
    logic signed [DW-1:0] integ_nxt;
    logic signed [DW-1:0] out_nxt;
    logic signed [DW-1:0] err;       // halved error, keeps sum in range
    logic signed [DW-1:0] sum;

    // next state: both operands halved before subtract to avoid overflow
    always_comb begin
        err       = (setpoint >>> 1) - (measured >>> 1);
        integ_nxt = integ_r;
        out_nxt   = out_r;
        sum       = '0;
        if (step) begin
            integ_nxt = integ_r + (err >>> KI_SHIFT);
            sum       = (integ_nxt >>> 1) + ((err >>> KP_SHIFT) >>> 1);
            out_nxt   = sum <<< 1;
        end
    end

    // registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            integ_r <= '0;
            out_r   <= '0;
        end else if (clk_en) begin
            integ_r <= integ_nxt;
            out_r   <= out_nxt;
        end
    end
endmodule

// ### svpwm_pkg.sv
// svpwm_pkg: shared constants for the space-vector pwm sector sequencer
// assumes a 25 MHz system clock; all counts derive from that rate
package svpwm_pkg;
    // clock and pwm period timing
    localparam int CLK_HZ          = 25000000;
    localparam int PWM_PERIOD_NS   = 41600;   // 41.6 us, 24 kHz
    localparam int CLK_PERIOD_NS   = 40;
    localparam int PWM_PERIOD_CYC  = PWM_PERIOD_NS / CLK_PERIOD_NS;
    // budget for per-period work: 327 cycles at 50 ns
    localparam int BUDGET_NS       = 327 * 50;
    localparam int BUDGET_CYC      = BUDGET_NS / CLK_PERIOD_NS;
    // open-loop startup time in pwm periods (default 1 s at 24 kHz)
    localparam int STARTUP_PERIODS = 24000;
    // data widths
    localparam int DW = 16;
    // phase channel codes, one-hot
    localparam logic [2:0] CH_A = 3'h1;
    localparam logic [2:0] CH_B = 3'h2;
    localparam logic [2:0] CH_C = 3'h4;
    // sector angle boundaries, 16-bit full turn
    localparam logic [15:0] ANG_60  = 16'h2AAA;
    localparam logic [15:0] ANG_120 = 16'h5555;
    localparam logic [15:0] ANG_180 = 16'h8000;
    localparam logic [15:0] ANG_240 = 16'hAAAA;
    localparam logic [15:0] ANG_300 = 16'hD555;
    // speed setpoint defaults
    localparam logic [15:0] SETPOINT_RST  = 16'h0100;
    localparam logic [15:0] SETPOINT_STEP = 16'h0001;
    localparam logic [15:0] SETPOINT_MAX  = 16'h7FFF;
    // pi gains as right-shift amounts
    localparam int KP_SHIFT = 2;
    localparam int KI_SHIFT = 6;
endpackage

// ### svpwm_sector.sv
// svpwm_sector: sector lookup and channel toggle ordering
// assumes angle and ordering inputs are stable within the evaluation cycle
`timescale 1ns/1ps
module svpwm_sector
    import svpwm_pkg::*;
(
    // reference angle
    input  wire logic [15:0] angle,
    // results
    output logic [2:0]       sector,
    output logic [2:0]       first_ch,
    output logic [2:0]       second_ch,
    output logic [2:0]       third_ch
);
    // sector 1..6 from 60 degree boundaries
    always_comb begin
        if (angle <= ANG_60) begin
            sector = 3'h1;
        end else if (angle <= ANG_120) begin
            sector = 3'h2;
        end else if (angle <= ANG_180) begin
            sector = 3'h3;
        end else if (angle <= ANG_240) begin
            sector = 3'h4;
        end else if (angle <= ANG_300) begin
            sector = 3'h5;
        end else begin
            sector = 3'h6;
        end
    end

    // order tables chosen so one channel toggles per edge
    always_comb begin
        case (sector)
            3'h1: begin first_ch = CH_A; second_ch = CH_B; end
            3'h2: begin first_ch = CH_B; second_ch = CH_A; end
            3'h3: begin first_ch = CH_B; second_ch = CH_C; end
            3'h4: begin first_ch = CH_C; second_ch = CH_B; end
            3'h5: begin first_ch = CH_C; second_ch = CH_A; end
            3'h6: begin first_ch = CH_A; second_ch = CH_C; end
            default: begin first_ch = CH_A; second_ch = CH_B; end
        endcase
        // third is the remaining channel
        third_ch = ~(first_ch | second_ch) & 3'h7;
    end
endmodule

// ### svpwm_sector_sequencer.sv
// svpwm_sector_sequencer: top of the space-vector pwm sequencer
// assumes inputs synchronous to clk_sys; decomposition matrix rows from host
//
// Overview of operation
// - outputs step 000, x, y, 111, y, x, 000
// - direction with single channel change per edge
// - first channel per sector: A,B,B,C,C,A
// - sector one second channel is B
// - third channel is the remaining one
// - compares: t0, t0+t1, t0+t1+t2 together
// - compare values are integer timer counts
// - negative active half-times forced to zero
// - sector found against 60 degree boundaries
// - all processing triggered by period event
// - open loop start, then closed loop
// - pi skipped until loop-enable flag set
// - buttons sampled each period, change setpoint
// - speed measured only on capture flag
// - all tasks share the 24 kHz rate
// - processing finishes within one pwm period
// - speed regulator is proportional-integral
// - operands right-shifted one bit before adding
`timescale 1ns/1ps
module svpwm_sector_sequencer
    import svpwm_pkg::*;
#(
    parameter int PERIOD_CYC   = PWM_PERIOD_CYC,   // timer cycles per pwm period
    parameter int STARTUP_CNT  = STARTUP_PERIODS   // open-loop periods
)
(
    // clock, reset, enable
    input  wire logic                 clk_sys,
    input  wire logic                 rstn,
    input  wire logic                 clk_en,
    // control
    input  wire logic                 start,
    // reference vector
    input  wire logic [15:0]          ref_angle,
    input  wire logic signed [DW-1:0] ref_voltage_d,
    input  wire logic signed [DW-1:0] ref_voltage_q,
    // decomposition matrix for current sector, Q15
    input  wire logic signed [DW-1:0] mat_11,
    input  wire logic signed [DW-1:0] mat_12,
    input  wire logic signed [DW-1:0] mat_21,
    input  wire logic signed [DW-1:0] mat_22,
    // operator and sensor inputs
    input  wire logic                 speed_up_button,
    input  wire logic                 speed_down_button,
    input  wire logic                 capture_flag,
    input  wire logic [DW-1:0]        capture_count,
    // compare outputs
    output logic [DW-1:0]             phase_a_compare,
    output logic [DW-1:0]             phase_b_compare,
    output logic [DW-1:0]             phase_c_compare,
    // gate state outputs
    output logic [2:0]                phase_out,
    // status
    output logic                      period_event,
    output logic                      closed_loop_enable_flag,
    output logic [2:0]                sector_out,
    output logic [DW-1:0]             speed_setpoint,
    output logic [DW-1:0]             measured_speed,
    output logic signed [DW-1:0]      speed_command
);
    localparam int TW = $clog2(PERIOD_CYC + 1);
    localparam int SW = $clog2(STARTUP_CNT + 1);

    typedef enum logic [3:0] {
        SVPWM_IDLE  = 4'h1,   // waiting for start
        SVPWM_OPEN  = 4'h2,   // open-loop startup
        SVPWM_CLOSE = 4'h4,   // closed loop running
        SVPWM_RSVD  = 4'h8    // unused code
    } svpwm_mode_t;

    // reset synchroniser
    logic       rst_s1_r;      // first stage, read only by second
    logic       rst_n;         // released reset

    // period timer
    logic [TW-1:0] tmr_r, tmr_nxt;        // up-down timer count
    logic          dir_r, dir_nxt;        // 1 counting down
    logic          evt_r, evt_nxt;        // period event pulse

    // mode control
    svpwm_mode_t   mode_r, mode_nxt;
    logic [SW-1:0] start_cnt_r, start_cnt_nxt;
    logic          loop_on_r, loop_on_nxt;

    // compare and sector state
    logic [DW-1:0] cmp_a_r, cmp_a_nxt;
    logic [DW-1:0] cmp_b_r, cmp_b_nxt;
    logic [DW-1:0] cmp_c_r, cmp_c_nxt;
    logic [2:0]    sec_r, sec_nxt;
    logic [2:0]    ph_r, ph_nxt;

    // speed state
    logic [DW-1:0] setp_r, setp_nxt;
    logic [DW-1:0] spd_r, spd_nxt;
    logic          pi_step;

    // sector decoder results
    logic [2:0]    sector, ch1, ch2, ch3;
    logic [DW-1:0] t0, t1, t2;

    // half-time from one matrix row: Q15 products summed, clamp, integer
    function automatic logic [DW-1:0] half_time(
        input logic signed [DW-1:0] m1,
        input logic signed [DW-1:0] m2,
        input logic signed [DW-1:0] ud,
        input logic signed [DW-1:0] uq
    );
        logic signed [2*DW-1:0] p1;
        logic signed [2*DW-1:0] p2;
        logic signed [2*DW:0]   s;
        p1 = m1 * ud;
        p2 = m2 * uq;
        s  = {p1[2*DW-1], p1} + {p2[2*DW-1], p2};
        // negative durations would wrap the compare, so clamp
        if (s < 0) begin
            half_time = '0;
        end else begin
            half_time = s[DW+14:15];  // drop fraction bits
        end
    endfunction

    // compare value for one channel by its toggle rank
    function automatic logic [DW-1:0] rank_cmp(
        input logic [2:0]    ch,
        input logic [2:0]    c1,
        input logic [2:0]    c2,
        input logic [DW-1:0] a,
        input logic [DW-1:0] b,
        input logic [DW-1:0] c
    );
        if (ch == c1) begin
            rank_cmp = a;
        end else if (ch == c2) begin
            rank_cmp = DW'(a + b);
        end else begin
            rank_cmp = DW'(a + b + c);
        end
    endfunction

    // sector and channel order lookup
    svpwm_sector u_sector (
        .angle     (ref_angle),
        .sector    (sector),
        .first_ch  (ch1),
        .second_ch (ch2),
        .third_ch  (ch3)
    );

    // speed regulator
    svpwm_pi u_pi (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .step     (pi_step),
        .setpoint (setp_r),
        .measured (spd_r),
        .out_r    (speed_command)
    );

    // reset release through two flops
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_s1_r <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n    <= rst_s1_r;
        end
    end

    // timer: counts up to half the pwm period, then back down
    always_comb begin
        tmr_nxt = tmr_r;
        dir_nxt = dir_r;
        evt_nxt = 1'b0;
        if (!dir_r) begin
            if (tmr_r >= TW'(PERIOD_CYC / 2 - 1)) begin
                dir_nxt = 1'b1;
            end else begin
                tmr_nxt = tmr_r + 1'b1;
            end
        end else begin
            if (tmr_r == '0) begin
                dir_nxt = 1'b0;
                evt_nxt = 1'b1;  // one event per period
            end else begin
                tmr_nxt = tmr_r - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tmr_r <= '0;
            dir_r <= 1'b0;
            evt_r <= 1'b0;
        end else if (clk_en) begin
            tmr_r <= tmr_nxt;
            dir_r <= dir_nxt;
            evt_r <= evt_nxt;
        end
    end

    // active half-times; t1 and t2 clamped at zero
    assign t1 = half_time(mat_11, mat_12, ref_voltage_d, ref_voltage_q);
    assign t2 = half_time(mat_21, mat_22, ref_voltage_d, ref_voltage_q);
    // zero-vector time is what is left of the half period, split evenly
    always_comb begin
        logic [DW:0] used;
        used = {1'b0, t1} + {1'b0, t2};
        if (used >= (DW+1)'(PERIOD_CYC / 2)) begin
            t0 = '0;
        end else begin
            t0 = DW'(((DW+1)'(PERIOD_CYC / 2) - used) >> 1);
        end
    end

    // mode, startup timeout and loop flag
    always_comb begin
        mode_nxt      = mode_r;
        start_cnt_nxt = start_cnt_r;
        loop_on_nxt   = loop_on_r;
        case (mode_r)
            SVPWM_IDLE: begin
                if (start) begin
                    mode_nxt      = SVPWM_OPEN;
                    start_cnt_nxt = '0;
                end
            end
            SVPWM_OPEN: begin
                // count periods of open-loop run
                if (evt_r) begin
                    if (start_cnt_r >= SW'(STARTUP_CNT - 1)) begin
                        mode_nxt    = SVPWM_CLOSE;
                        loop_on_nxt = 1'b1;
                    end else begin
                        start_cnt_nxt = start_cnt_r + 1'b1;
                    end
                end
            end
            SVPWM_CLOSE: begin
                loop_on_nxt = 1'b1;
            end
            default: begin
                mode_nxt    = SVPWM_IDLE;
                loop_on_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode_r      <= SVPWM_IDLE;
            start_cnt_r <= '0;
            loop_on_r   <= 1'b0;
        end else if (clk_en) begin
            mode_r      <= mode_nxt;
            start_cnt_r <= start_cnt_nxt;
            loop_on_r   <= loop_on_nxt;
        end
    end

    // pi runs only on period events once the loop flag is set
    assign pi_step = evt_r & loop_on_r;

    // per-period work: compares, setpoint, speed measurement
    // all of it settles in one cycle, well inside the period budget
    always_comb begin
        cmp_a_nxt = cmp_a_r;
        cmp_b_nxt = cmp_b_r;
        cmp_c_nxt = cmp_c_r;
        sec_nxt   = sec_r;
        setp_nxt  = setp_r;
        spd_nxt   = spd_r;
        if (evt_r) begin
            sec_nxt   = sector;
            // all three loaded together, ranked by toggle order
            cmp_a_nxt = rank_cmp(CH_A, ch1, ch2, t0, t1, t2);
            cmp_b_nxt = rank_cmp(CH_B, ch1, ch2, t0, t1, t2);
            cmp_c_nxt = rank_cmp(CH_C, ch1, ch2, t0, t1, t2);
            // buttons checked every period; no press, no change
            if (speed_up_button && !speed_down_button) begin
                if (setp_r < SETPOINT_MAX) begin
                    setp_nxt = setp_r + SETPOINT_STEP;
                end
            end else if (speed_down_button && !speed_up_button) begin
                if (setp_r != '0) begin
                    setp_nxt = setp_r - SETPOINT_STEP;
                end
            end
            // speed measured only with a valid hall capture
            if (capture_flag) begin
                spd_nxt = capture_count;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cmp_a_r <= '0;
            cmp_b_r <= '0;
            cmp_c_r <= '0;
            sec_r   <= 3'h1;
            setp_r  <= SETPOINT_RST;
            spd_r   <= '0;
        end else if (clk_en) begin
            cmp_a_r <= cmp_a_nxt;
            cmp_b_r <= cmp_b_nxt;
            cmp_c_r <= cmp_c_nxt;
            sec_r   <= sec_nxt;
            setp_r  <= setp_nxt;
            spd_r   <= spd_nxt;
        end
    end

    // gate outputs: channel high while timer is at or above its compare
    // rising ramp gives 000,x,y,111 and falling ramp the reverse
    always_comb begin
        ph_nxt = 3'h0;
        if (mode_r != SVPWM_IDLE) begin
            // compare at full width: cutting the compare to the timer width
            // would alias large counts and let two channels switch at once
            ph_nxt[0] = (DW'(tmr_r) >= cmp_a_r);
            ph_nxt[1] = (DW'(tmr_r) >= cmp_b_r);
            ph_nxt[2] = (DW'(tmr_r) >= cmp_c_r);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ph_r <= 3'h0;
        end else if (clk_en) begin
            ph_r <= ph_nxt;
        end
    end

    // outputs
    assign phase_a_compare         = cmp_a_r;
    assign phase_b_compare         = cmp_b_r;
    assign phase_c_compare         = cmp_c_r;
    assign phase_out               = ph_r;
    assign period_event            = evt_r;
    assign closed_loop_enable_flag = loop_on_r;
    assign sector_out              = sec_r;
    assign speed_setpoint          = setp_r;
    assign measured_speed          = spd_r;
endmodule

// ### svpwm_seq_checker.sv
// svpwm_seq_checker: port-level assertions for the sector sequencer
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module svpwm_seq_checker
    import svpwm_pkg::*;
#(
    parameter int PERIOD_CYC  = 64,  // cycles per pwm period
    parameter int STARTUP_CNT = 4    // open-loop periods
)
(
    // clock and reset
    input wire logic                 clk_sys,
    input wire logic                 rstn,
    // watched inputs
    input wire logic                 speed_up_button,
    input wire logic                 speed_down_button,
    input wire logic                 capture_flag,
    // watched outputs
    input wire logic [DW-1:0]        phase_a_compare,
    input wire logic [DW-1:0]        phase_b_compare,
    input wire logic [DW-1:0]        phase_c_compare,
    input wire logic [2:0]           phase_out,
    input wire logic                 period_event,
    input wire logic                 closed_loop_enable_flag,
    input wire logic [2:0]           sector_out,
    input wire logic [DW-1:0]        speed_setpoint,
    input wire logic [DW-1:0]        measured_speed,
    input wire logic signed [DW-1:0] speed_command
);
    localparam int FST [6] = '{0, 1, 1, 2, 2, 0};  // first channel by sector
    localparam int SND [6] = '{1, 0, 2, 1, 0, 2};  // second channel by sector
    logic [DW-1:0] cmp [3];           // compares indexed a, b, c
    logic [47:0]   cmps;              // all compares packed
    logic [15:0]   gap_r, gap_nxt;    // cycles since last event
    logic          seen_r, seen_nxt;  // an event was already seen
    int            fi, si;            // first, second channel of sector
    assign cmp[0] = phase_a_compare;
    assign cmp[1] = phase_b_compare;
    assign cmp[2] = phase_c_compare;
    assign cmps   = {phase_a_compare, phase_b_compare, phase_c_compare};
    // wrap keeps the index legal even on a bad sector code
    always_comb begin
        fi = FST[(int'(sector_out) + 5) % 6];
        si = SND[(int'(sector_out) + 5) % 6];
    end
    // spacing counter between period events
    always_comb begin
        gap_nxt  = period_event ? 16'h0000 : gap_r + 16'h0001;
        seen_nxt = seen_r | period_event;
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            gap_r  <= 16'h0000;
            seen_r <= 1'b0;
        end else begin
            gap_r  <= gap_nxt;
            seen_r <= seen_nxt;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    period_gap_a: assert property (period_event && seen_r |-> gap_r == 16'(PERIOD_CYC - 1))
        else $error("period event spacing wrong");
    cmp_update_a: assert property ($changed(cmps) |-> $past(period_event))
        else $error("compares changed outside update");
    sector_range_a: assert property (sector_out inside {[3'h1:3'h6]})
        else $error("sector out of range");
    cmp_order_a: assert property ($past(period_event) |->
        cmp[fi] <= cmp[si] && cmp[si] <= cmp[3 - fi - si])
        else $error("compare order wrong for sector");
    single_toggle_a: assert property (cmps == $past(cmps, 2) && cmp[0] != cmp[1]
        && cmp[1] != cmp[2] && cmp[0] != cmp[2]
        |-> $countones(phase_out ^ $past(phase_out)) <= 1)
        else $error("more than one phase toggled");
    pi_hold_a: assert property (!closed_loop_enable_flag |-> speed_command == 16'sh0000)
        else $error("speed command moved in open loop");
    loop_sticky_a: assert property ($past(closed_loop_enable_flag) |-> closed_loop_enable_flag)
        else $error("loop flag dropped");
    meas_gate_a: assert property ($changed(measured_speed)
        |-> $past(period_event) && $past(capture_flag))
        else $error("speed measured without capture");
    setpoint_gate_a: assert property ($changed(speed_setpoint) |-> $past(period_event)
        && $past(speed_up_button) != $past(speed_down_button))
        else $error("setpoint changed without one button");
endmodule
bind svpwm_sector_sequencer svpwm_seq_checker #(
    .PERIOD_CYC(PERIOD_CYC), .STARTUP_CNT(STARTUP_CNT)
) u_chk (
    .clk_sys(clk_sys), .rstn(rstn), .speed_up_button(speed_up_button),
    .speed_down_button(speed_down_button), .capture_flag(capture_flag),
    .phase_a_compare(phase_a_compare), .phase_b_compare(phase_b_compare),
    .phase_c_compare(phase_c_compare), .phase_out(phase_out),
    .period_event(period_event), .closed_loop_enable_flag(closed_loop_enable_flag),
    .sector_out(sector_out), .speed_setpoint(speed_setpoint),
    .measured_speed(measured_speed), .speed_command(speed_command)
);

// ### testbench.sv
// testbench: self-checking bench for the sector sequencer
// assumes short period and startup parameters; the checker is bound in
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fails++; \
    $display("BAD %0t got %0h exp %0h", $time, got, exp); end end
module testbench;
    import svpwm_pkg::*;
    localparam int PER = 64;  // short period keeps the run brief
    localparam int SUC = 4;   // short open-loop phase
    localparam int FST [6] = '{0, 1, 1, 2, 2, 0};
    localparam int SND [6] = '{1, 0, 2, 1, 0, 2};
    localparam logic [15:0] BND [6] = '{ANG_60, ANG_120, ANG_180, ANG_240, ANG_300, 16'hFFFF};
    logic                 clk_sys, rstn, start, up, dn, cap, ev, flag;
    logic [15:0]          ang, ccnt;
    logic signed [DW-1:0] ud, uq, m11, m12, m21, m22, cmd;
    logic [DW-1:0]        pa, pb, pc, sp_o, ms;
    logic [2:0]           ph, sec;
    logic [DW-1:0]        c [3];              // compares indexed a, b, c
    int                   fails, n_compared;  // verdict counters
    int                   sp_m, mode, k, f, s, t, sec_e;
    int                   t0m, t1m, t2m, ms_m, ig, er, cm, pf;  // model state
    svpwm_sector_sequencer #(.PERIOD_CYC(PER), .STARTUP_CNT(SUC)) uut (
        .clk_sys(clk_sys), .rstn(rstn), .clk_en(1'b1), .start(start),
        .ref_angle(ang), .ref_voltage_d(ud), .ref_voltage_q(uq),
        .mat_11(m11), .mat_12(m12), .mat_21(m21), .mat_22(m22),
        .speed_up_button(up), .speed_down_button(dn),
        .capture_flag(cap), .capture_count(ccnt),
        .phase_a_compare(pa), .phase_b_compare(pb), .phase_c_compare(pc),
        .phase_out(ph), .period_event(ev), .closed_loop_enable_flag(flag),
        .sector_out(sec), .speed_setpoint(sp_o), .measured_speed(ms),
        .speed_command(cmd)
    );
    svpwm_hall_model #(.EVERY(3)) u_hall (
        .clk_sys(clk_sys), .period_event(ev), .capture_flag(cap), .capture_count(ccnt)
    );
    // 25 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // hang guard, about twice the expected run
    initial begin
        repeat (4000) @(posedge clk_sys);
        fails++;
        final_report();
    end
    task automatic final_report();
        if (fails == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // sector from angle, boundaries inclusive
    function automatic int sec_of(input logic [15:0] a);
        if (a <= ANG_60) return 1;
        if (a <= ANG_120) return 2;
        if (a <= ANG_180) return 3;
        if (a <= ANG_240) return 4;
        if (a <= ANG_300) return 5;
        return 6;
    endfunction
    // new per-period inputs; mode picks which matrix rows go negative
    task automatic drive();
        mode = $urandom % 4;
        ang  = (k < 6) ? BND[k] : 16'($urandom);
        ud   = {2'b00, 14'($urandom)};
        uq   = {2'b00, 14'($urandom)};
        m11  = (mode == 1 || mode == 3) ? 16'shE000 : 16'sh2000;
        m12  = m11;
        m21  = (mode == 1 || mode == 2) ? 16'shE000 : 16'sh2000;
        m22  = m21;
        up   = 1'($urandom);
        dn   = 1'($urandom);
    endtask
    // bounded wait for the period pulse, seen at a falling edge
    task automatic wait_ev();
        int n;
        n = 0;
        @(negedge clk_sys);
        while (ev !== 1'b1 && n < 200) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 200) fails++;
    endtask
    // compare results one cycle after the event against the model
    task automatic check();
        sec_e = sec_of(ang);
        f = FST[sec_e - 1];
        s = SND[sec_e - 1];
        t = 3 - f - s;
        c[0] = pa;
        c[1] = pb;
        c[2] = pc;
        // half-times from the matrix rows, negative ones forced to zero
        t1m = (m11 * ud + m12 * uq) >>> 15;
        if (t1m < 0) t1m = 0;
        t2m = (m21 * ud + m22 * uq) >>> 15;
        if (t2m < 0) t2m = 0;
        t0m = (t1m + t2m >= PER / 2) ? 0 : (PER / 2 - t1m - t2m) / 2;
        // pi steps with last period's setpoint and speed when loop was on
        if (pf != 0) begin
            er = (sp_m >>> 1) - (ms_m >>> 1);
            ig = ig + (er >>> KI_SHIFT);
            cm = ((ig >>> 1) + ((er >>> KP_SHIFT) >>> 1)) * 2;
        end
        if (cap) ms_m = int'(ccnt);
        if (up && !dn && sp_m < int'(SETPOINT_MAX)) sp_m++;
        if (dn && !up && sp_m > 0) sp_m--;
        `CHK(sec, 3'(sec_e))
        `CHK(sp_o, 16'(sp_m))
        case (mode)
            0: `CHK(1'(c[f] <= c[s] && c[s] <= c[t]), 1'b1)
            1: begin
                `CHK(c[f], 16'(PER / 4))
                `CHK(c[t], 16'(PER / 4))
            end
            2: `CHK(c[s], c[t])
            default: `CHK(c[f], c[s])
        endcase
        if (k < SUC - 1) `CHK(flag, 1'b0)
        if (k > SUC + 2) `CHK(flag, 1'b1)
        if (!flag) `CHK(cmd, 16'sh0000)
        `CHK(c[f], 16'(t0m))
        `CHK(c[s], 16'(t0m + t1m))
        `CHK(c[t], 16'(t0m + t1m + t2m))
        `CHK(ms, 16'(ms_m))
        `CHK(cmd, 16'(cm))
        pf = (flag === 1'b1) ? 1 : 0;
    endtask
    // main sequence
    initial begin
        fails = 0;
        n_compared = 0;
        k = 0;
        rstn = 1'b0;
        start = 1'b0;
        sp_m = int'(SETPOINT_RST);
        void'($urandom(65));
        drive();
        repeat (20) @(posedge clk_sys);
        @(negedge clk_sys);
        rstn = 1'b1;
        repeat (3) @(negedge clk_sys);
        start = 1'b1;
        for (k = 0; k < 30; k++) begin
            drive();
            wait_ev();
            @(negedge clk_sys);
            check();
        end
        final_report();
    end
endmodule
